// *** lefs_pkg.sv ***
// constants and types for the lane error and status flag block
`default_nettype none
package lefs_pkg;
    // ==========================================
    // low-power line states as {dp, dn}
    localparam logic [1:0] LS_STOP = 2'h3;
    localparam logic [1:0] LS_MARK1 = 2'h2;
    localparam logic [1:0] LS_MARK0 = 2'h1;
    localparam logic [1:0] LS_BRIDGE = 2'h0;
    // ==========================================
    // escape entry command decoding
    localparam int CMD_BITS = 8;
    localparam logic [3:0] CMD_LEN = 4'h8;
    localparam logic [2:0] LPDT_ALIGN = 3'h0;
    // ==========================================
    // wake-up interval and clock rate
    localparam int CLK_HZ = 20_000_000;
    localparam int NS_PER_S = 1_000_000_000;
    localparam int WAKE_CNT_W = 16;
    // ==========================================
    // receive line sequence states, gray along the escape path
    typedef enum logic [2:0] {
        ST_STOP = 3'h0,
        ST_RQST = 3'h1,
        ST_BRG = 3'h3,
        ST_ESC_RQ = 3'h2,
        ST_ESC_BRG = 3'h6,
        ST_ESC_MARK = 3'h7,
        ST_ULPS = 3'h5,
        ST_WAIT = 3'h4
    } lefs_state_t;
endpackage : lefs_pkg
`default_nettype wire

// *** lefs_sync.sv ***
// two-flop synchroniser, one chain per bit
`default_nettype none
`timescale 1ns/1ns
module lefs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    if (WIDTH < 1) begin : g_bad_width
        $error("lefs_sync: WIDTH must be at least 1");
    end

    // ==========================================
    // per-bit chains; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_q;
            logic meta_d;
            logic stab_q;
            logic stab_d;
            // next values
            always_comb begin
                meta_d = async_in[i];
                stab_d = meta_q;
            end
            // registers
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    stab_q <= stab_d;
                end
            end
            assign sync_out[i] = stab_q;
        end
    endgenerate
endmodule : lefs_sync
`default_nettype wire

// *** lefs_line_mon.sv ***
// line state register and change detector
`default_nettype none
`timescale 1ns/1ns
module lefs_line_mon (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // synchronised lane enable and line levels
    input wire logic en,
    input wire logic dp,
    input wire logic dn,
    // current line state and change pulse
    output logic [1:0] line_state,
    output logic line_chg
);
    logic [1:0] ls_q;
    logic [1:0] ls_d;
    logic chg_q;
    logic chg_d;

    // ==========================================
    // track state; a change pulses for one cycle
    always_comb begin
        ls_d = lefs_pkg::LS_STOP;
        chg_d = 1'b0;
        if (en) begin
            ls_d = {dp, dn};
            chg_d = ({dp, dn} != ls_q);
        end
    end

    // registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ls_q <= lefs_pkg::LS_STOP;
            chg_q <= 1'b0;
        end else begin
            ls_q <= ls_d;
            chg_q <= chg_d;
        end
    end

    assign line_state = ls_q;
    assign line_chg = chg_q;
endmodule : lefs_line_mon
`default_nettype wire

// *** lefs_flags.sv ***
// receive-side ulps status and error flags of a serial lane
`default_nettype none
`timescale 1ns/1ns
// Overview of operation
// RULE1: ulps_active_n falls with the ulps indication
// RULE2: ulps_active_n rises once mark-one is seen
// RULE3: drop ulps indication after wake-up interval
// RULE4: soft leader error pulses one cycle
// RULE5: unsyncable leader error pulses one cycle
// RULE6: unknown escape command flag held till change
// RULE7: lpdt bit count misaligned flag held
// RULE8: illegal line sequence flag held till change
// RULE9: request then stop without bridge is illegal
// RULE10: contention flag while driving low
// RULE11: contention flag while driving high
// RULE12: enable low forces all outputs inactive
// RULE13: clock-lane ulps held until stop state
module lefs_flags #(
    parameter int WAKEUP_NS = 1000,
    parameter logic [7:0] CMD_LPDT = 8'h87,
    parameter logic [7:0] CMD_ULPS = 8'h78
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // lane control pins
    input wire logic enable,
    input wire logic is_clock_lane,
    // line levels and contention detector pins
    input wire logic dp,
    input wire logic dn,
    input wire logic contention_det,
    // local transmitter drive state, same clock
    input wire logic drive_en,
    input wire logic drive_level,
    // start leader checker events, same clock
    input wire logic sot_soft_event,
    input wire logic sot_sync_event,
    // ulps status
    output logic ulps_active_n,
    output logic rx_data_lane_ulps,
    output logic rx_clock_lane_ulps_n,
    // error flags
    output logic sot_soft_err,
    output logic sot_sync_err,
    output logic esc_entry_err,
    output logic lpdt_sync_err,
    output logic line_seq_err,
    output logic contention_low_err,
    output logic contention_high_err
);
    localparam int WAKE_CYC_RAW = (WAKEUP_NS * (lefs_pkg::CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
    localparam logic [lefs_pkg::WAKE_CNT_W-1:0] WAKE_LOAD = WAKE_CYC[lefs_pkg::WAKE_CNT_W-1:0];
    localparam logic [lefs_pkg::WAKE_CNT_W-1:0] WAKE_ZERO = '0;
    localparam logic [lefs_pkg::WAKE_CNT_W-1:0] WAKE_ONE = {{(lefs_pkg::WAKE_CNT_W-1){1'b0}}, 1'b1};

    if (WAKE_CYC >= (1 << lefs_pkg::WAKE_CNT_W)) begin : g_bad_wake
        $error("lefs_flags: WAKEUP_NS too large for wake counter");
    end

    // ==========================================
    // synchronised pins
    logic [3:0] pin_s;
    logic en_s;
    logic [1:0] ls;
    logic chg;

    lefs_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({enable, dp, dn, contention_det}),
        .sync_out(pin_s)
    );
    assign en_s = pin_s[3];

    lefs_line_mon u_mon (
        .clk(clk),
        .resetn(resetn),
        .en(en_s),
        .dp(pin_s[2]),
        .dn(pin_s[1]),
        .line_state(ls),
        .line_chg(chg)
    );

    // ==========================================
    // sequence state and escape decoding
    lefs_pkg::lefs_state_t st_q, st_d;
    logic [7:0] cmd_q, cmd_d;
    logic [3:0] cnt_q, cnt_d;
    logic lpdt_q, lpdt_d;
    logic seq_set, esc_set, sync_set, ulps_enter;

    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        cnt_d = cnt_q;
        lpdt_d = lpdt_q;
        seq_set = 1'b0;
        esc_set = 1'b0;
        sync_set = 1'b0;
        ulps_enter = 1'b0;
        if (!en_s) begin
            st_d = lefs_pkg::ST_STOP; // RULE12
            cnt_d = '0;
            lpdt_d = 1'b0;
        end else if (chg) begin
            case (st_q)
                lefs_pkg::ST_STOP: begin
                    if (ls == lefs_pkg::LS_MARK1) begin
                        st_d = lefs_pkg::ST_RQST;
                    end else if (ls == lefs_pkg::LS_MARK0) begin
                        st_d = lefs_pkg::ST_WAIT; // high-speed entry
                    end else begin
                        seq_set = 1'b1; // RULE8
                        st_d = lefs_pkg::ST_WAIT;
                    end
                end
                lefs_pkg::ST_RQST: begin
                    if (ls == lefs_pkg::LS_BRIDGE) begin
                        st_d = is_clock_lane ? lefs_pkg::ST_ULPS : lefs_pkg::ST_BRG;
                        ulps_enter = is_clock_lane;
                    end else begin
                        seq_set = 1'b1; // RULE9
                        st_d = (ls == lefs_pkg::LS_STOP) ? lefs_pkg::ST_STOP : lefs_pkg::ST_WAIT;
                    end
                end
                lefs_pkg::ST_BRG: begin
                    if (ls == lefs_pkg::LS_MARK0) begin
                        st_d = lefs_pkg::ST_ESC_RQ;
                    end else if (ls == lefs_pkg::LS_MARK1) begin
                        st_d = lefs_pkg::ST_WAIT; // turn-around, handled elsewhere
                    end else begin
                        seq_set = 1'b1; // RULE8
                        st_d = lefs_pkg::ST_STOP;
                    end
                end
                lefs_pkg::ST_ESC_RQ: begin
                    if (ls == lefs_pkg::LS_BRIDGE) begin
                        st_d = lefs_pkg::ST_ESC_BRG;
                        cnt_d = '0;
                        lpdt_d = 1'b0;
                    end else begin
                        seq_set = 1'b1; // RULE9
                        st_d = (ls == lefs_pkg::LS_STOP) ? lefs_pkg::ST_STOP : lefs_pkg::ST_WAIT;
                    end
                end
                lefs_pkg::ST_ESC_BRG: begin
                    if (ls == lefs_pkg::LS_STOP) begin
                        st_d = lefs_pkg::ST_STOP;
                        lpdt_d = 1'b0;
                    end else begin
                        st_d = lefs_pkg::ST_ESC_MARK;
                        cmd_d = {cmd_q[6:0], (ls == lefs_pkg::LS_MARK1)};
                    end
                end
                lefs_pkg::ST_ESC_MARK: begin
                    if (ls == lefs_pkg::LS_BRIDGE) begin
                        st_d = lefs_pkg::ST_ESC_BRG;
                        cnt_d = cnt_q + 4'h1;
                        if (!lpdt_q && (cnt_q + 4'h1) == lefs_pkg::CMD_LEN) begin
                            cnt_d = '0;
                            if (cmd_q == CMD_LPDT) begin
                                lpdt_d = 1'b1;
                            end else if (cmd_q == CMD_ULPS) begin
                                st_d = lefs_pkg::ST_ULPS;
                                ulps_enter = 1'b1;
                            end else begin
                                esc_set = 1'b1; // RULE6
                                st_d = lefs_pkg::ST_WAIT;
                            end
                        end
                    end else if (ls == lefs_pkg::LS_STOP) begin
                        // exit mark is not a data bit
                        sync_set = lpdt_q && (cnt_q[2:0] != lefs_pkg::LPDT_ALIGN); // RULE7
                        seq_set = !lpdt_q; // RULE8
                        lpdt_d = 1'b0;
                        st_d = lefs_pkg::ST_STOP;
                    end else begin
                        seq_set = 1'b1; // RULE8
                        st_d = lefs_pkg::ST_WAIT;
                    end
                end
                lefs_pkg::ST_ULPS: begin
                    if (ls == lefs_pkg::LS_STOP) begin
                        st_d = lefs_pkg::ST_STOP;
                    end
                end
                lefs_pkg::ST_WAIT: begin
                    if (ls == lefs_pkg::LS_STOP) begin
                        st_d = lefs_pkg::ST_STOP;
                    end
                end
                default: begin
                    st_d = lefs_pkg::ST_STOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= lefs_pkg::ST_STOP;
            cmd_q <= '0;
            cnt_q <= '0;
            lpdt_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            cnt_q <= cnt_d;
            lpdt_q <= lpdt_d;
        end
    end

    // ==========================================
    // ulps status and wake-up timer
    logic act_n_q, act_n_d, ind_q, ind_d;
    logic [lefs_pkg::WAKE_CNT_W-1:0] wake_q, wake_d;

    always_comb begin
        act_n_d = act_n_q;
        ind_d = ind_q;
        wake_d = wake_q;
        if (!en_s) begin
            act_n_d = 1'b1; // RULE12
            ind_d = 1'b0;
            wake_d = WAKE_ZERO;
        end else if (ulps_enter) begin
            act_n_d = 1'b0; // RULE1
            ind_d = 1'b1;
        end else if (ind_q && !act_n_q && chg && ls == lefs_pkg::LS_MARK1) begin
            act_n_d = 1'b1; // RULE2
            wake_d = WAKE_LOAD;
        end else if (ind_q && act_n_q) begin
            if (wake_q != WAKE_ZERO) begin
                wake_d = wake_q - WAKE_ONE; // RULE3
            end else if (!is_clock_lane || ls == lefs_pkg::LS_STOP) begin
                ind_d = 1'b0; // RULE13
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_n_q <= 1'b1;
            ind_q <= 1'b0;
            wake_q <= WAKE_ZERO;
        end else begin
            act_n_q <= act_n_d;
            ind_q <= ind_d;
            wake_q <= wake_d;
        end
    end

    // ==========================================
    // held flags, pulses and contention
    logic esc_q, esc_d, sync_q, sync_d, seq_q, seq_d;
    logic soft_q, soft_d, hsync_q, hsync_d, cl_q, cl_d, ch_q, ch_d;

    // a set in the clearing cycle wins
    always_comb begin
        esc_d = en_s && (esc_set || (esc_q && !chg)); // RULE6
        sync_d = en_s && (sync_set || (sync_q && !chg)); // RULE7
        seq_d = en_s && (seq_set || (seq_q && !chg)); // RULE8
        soft_d = en_s && sot_soft_event; // RULE4
        hsync_d = en_s && sot_sync_event; // RULE5
        cl_d = en_s && drive_en && !drive_level && pin_s[0]; // RULE10
        ch_d = en_s && drive_en && drive_level && pin_s[0]; // RULE11
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            esc_q <= 1'b0;
            sync_q <= 1'b0;
            seq_q <= 1'b0;
            soft_q <= 1'b0;
            hsync_q <= 1'b0;
            cl_q <= 1'b0;
            ch_q <= 1'b0;
        end else begin
            esc_q <= esc_d;
            sync_q <= sync_d;
            seq_q <= seq_d;
            soft_q <= soft_d;
            hsync_q <= hsync_d;
            cl_q <= cl_d;
            ch_q <= ch_d;
        end
    end

    // outputs
    assign ulps_active_n = act_n_q;
    assign rx_data_lane_ulps = ind_q && !is_clock_lane;
    assign rx_clock_lane_ulps_n = !(ind_q && is_clock_lane);
    assign sot_soft_err = soft_q;
    assign sot_sync_err = hsync_q;
    assign esc_entry_err = esc_q;
    assign lpdt_sync_err = sync_q;
    assign line_seq_err = seq_q;
    assign contention_low_err = cl_q;
    assign contention_high_err = ch_q;

    // ==========================================
    // checks
    chk_ulps_entry_same: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        $rose(ind_q) |-> $fell(ulps_active_n))
        else $error("ulps indication without ulps_active_n");
    chk_ulps_mark_exit: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        $rose(ulps_active_n) && en_s |-> $past(ls) == lefs_pkg::LS_MARK1 && ind_q)
        else $error("ulps_active_n released without mark-one");
    chk_wake_interval: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        $rose(ulps_active_n) && ind_q |-> ind_q [*2])
        else $error("ulps indication dropped before wake-up");
    chk_soft_pulse: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        sot_soft_err |-> $past(sot_soft_event) && $past(en_s))
        else $error("sot_soft_err without leader event");
    chk_sync_pulse: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        $rose(sot_sync_err) && !sot_sync_event |=> !sot_sync_err)
        else $error("sot_sync_err longer than one cycle");
    chk_esc_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        esc_entry_err && !chg && en_s |=> esc_entry_err)
        else $error("esc_entry_err dropped without line change");
    chk_lpdt_hold: assert property (@(posedge clk) disable iff (!resetn) // RULE7
        lpdt_sync_err && !chg && en_s |=> lpdt_sync_err)
        else $error("lpdt_sync_err dropped without line change");
    chk_seq_bridge: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        chg && ls == lefs_pkg::LS_STOP && en_s
        && (st_q == lefs_pkg::ST_RQST || st_q == lefs_pkg::ST_ESC_RQ) |=> line_seq_err)
        else $error("missing bridge not flagged");
    chk_contend_low: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        contention_low_err |-> $past(drive_en) && !$past(drive_level))
        else $error("low contention flagged while not driving low");
    chk_enable_idle: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        !en_s ##1 !en_s |-> ulps_active_n && rx_clock_lane_ulps_n && !line_seq_err
        && !esc_entry_err && !contention_high_err && !sot_soft_err && !rx_data_lane_ulps)
        else $error("outputs active while lane disabled");
    chk_clk_ulps_stop: assert property (@(posedge clk) disable iff (!resetn) // RULE13
        $rose(rx_clock_lane_ulps_n) && en_s && is_clock_lane |-> $past(ls) == lefs_pkg::LS_STOP)
        else $error("clock-lane ulps released before stop state");
endmodule : lefs_flags
`default_nettype wire

// *** lefs_far_lane.sv ***
// far-side lane model that drives line levels and the contention detector
`timescale 1ns/1ns
`default_nettype none
module lefs_far_lane (
    // clock
    input wire logic clk,
    // local drive state and fight request from the bench
    input wire logic drive_en,
    input wire logic fight,
    // line levels and contention detector
    output logic dp,
    output logic dn,
    output logic contention_det
);
    // detector fires while the local end drives and the bench requests a fight
    assign contention_det = drive_en & fight;

    // line rests at stop
    initial begin
        dp = 1'b1;
        dn = 1'b1;
    end

    // =========================================
    // line stimulus
    // one line state, changed after an edge and held for n cycles
    task automatic line(input logic [1:0] s, input int n);
        @(posedge clk);
        {dp, dn} <= s;
        repeat (n - 1) @(posedge clk);
    endtask : line

    // one escape bit: mark then bridge
    task automatic bit_pair(input logic b);
        line(b ? lefs_pkg::LS_MARK1 : lefs_pkg::LS_MARK0, 2);
        line(lefs_pkg::LS_BRIDGE, 2);
    endtask : bit_pair

    // escape entry then an 8-bit command, msb first
    task automatic esc(input logic [7:0] cmd);
        line(lefs_pkg::LS_MARK1, 2);
        line(lefs_pkg::LS_BRIDGE, 2);
        line(lefs_pkg::LS_MARK0, 2);
        line(lefs_pkg::LS_BRIDGE, 2);
        for (int i = 7; i >= 0; i--) begin
            bit_pair(cmd[i]);
        end
    endtask : esc
endmodule : lefs_far_lane
`default_nettype wire

// *** lane_error_status_flags_tb_top.sv ***
// self-checking bench for the lane error and status flags
`timescale 1ns/1ns
`default_nettype none
module lane_error_status_flags_tb_top;
    // =========================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic enable = 1'b1;
    logic is_clock_lane = 1'b0;
    logic drive_en = 1'b0;
    logic drive_level = 1'b0;
    logic sot_soft_event = 1'b0;
    logic sot_sync_event = 1'b0;
    logic fight = 1'b0;
    logic dp;
    logic dn;
    logic contention_det;
    logic ulps_active_n;
    logic rx_data_lane_ulps;
    logic rx_clock_lane_ulps_n;
    logic sot_soft_err;
    logic sot_sync_err;
    logic esc_entry_err;
    logic lpdt_sync_err;
    logic line_seq_err;
    logic contention_low_err;
    logic contention_high_err;
    logic [9:0] flags;
    logic [1:0] ev;
    int bad_count = 0;
    int checked = 0;
    int seed = 57659;
    int q[$];

    // all outputs gathered, idle value 10'h280
    assign flags = {ulps_active_n, rx_data_lane_ulps, rx_clock_lane_ulps_n, sot_soft_err,
        sot_sync_err, esc_entry_err, lpdt_sync_err, line_seq_err, contention_low_err,
        contention_high_err};

    // 50 ns clock
    always #25 clk = ~clk;

    // =========================================
    // design and far-side model
    lefs_flags #(.WAKEUP_NS(100)) dut (
        .clk(clk), .resetn(resetn), .enable(enable), .is_clock_lane(is_clock_lane),
        .dp(dp), .dn(dn), .contention_det(contention_det), .drive_en(drive_en),
        .drive_level(drive_level), .sot_soft_event(sot_soft_event),
        .sot_sync_event(sot_sync_event), .ulps_active_n(ulps_active_n),
        .rx_data_lane_ulps(rx_data_lane_ulps), .rx_clock_lane_ulps_n(rx_clock_lane_ulps_n),
        .sot_soft_err(sot_soft_err), .sot_sync_err(sot_sync_err),
        .esc_entry_err(esc_entry_err), .lpdt_sync_err(lpdt_sync_err),
        .line_seq_err(line_seq_err), .contention_low_err(contention_low_err),
        .contention_high_err(contention_high_err)
    );
    lefs_far_lane u_far (
        .clk(clk), .drive_en(drive_en), .fight(fight), .dp(dp), .dn(dn),
        .contention_det(contention_det)
    );

    // =========================================
    // helpers
    // compare all flags at the falling edge
    task automatic cmp(input logic [9:0] exp);
        @(negedge clk);
        checked++;
        if (flags !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, flags, exp);
        end
    endtask : cmp

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n

    // counts, verdict and end of run
    task automatic summarize;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // =========================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        wait_n(6);
        cmp(10'h280);
        $display("test reset done");
        // leader pulses: model queue delays each event by one cycle
        q.push_back(0);
        for (int i = 0; i < 17; i++) begin
            ev = (i == 16) ? 2'h0 : 2'($random(seed));
            @(posedge clk);
            sot_soft_event <= ev[1];
            sot_sync_event <= ev[0];
            q.push_back(ev);
            cmp(10'h280 | {3'h0, 2'(q.pop_front()), 5'h00});
        end
        q.delete();
        $display("test leader done");
        // contention while driving low, then high
        for (int lv = 0; lv < 2; lv++) begin
            @(posedge clk);
            drive_en <= 1'b1;
            fight <= 1'b1;
            drive_level <= lv[0];
            wait_n(5);
            cmp(lv[0] ? 10'h281 : 10'h282);
        end
        @(posedge clk);
        fight <= 1'b0;
        drive_en <= 1'b0;
        wait_n(5);
        cmp(10'h280);
        $display("test contention done");
        // unknown escape command, held until the line changes
        u_far.esc(8'h5a);
        wait_n(4);
        cmp(10'h290);
        wait_n(6);
        cmp(10'h290);
        u_far.line(lefs_pkg::LS_STOP, 5);
        cmp(10'h280);
        $display("test escape done");
        // low-power data with 5 random bits, then with 8
        for (int n = 5; n <= 8; n += 3) begin
            u_far.esc(dut.CMD_LPDT);
            for (int b = 0; b < n; b++) begin
                u_far.bit_pair(1'($random(seed)));
            end
            u_far.line(lefs_pkg::LS_MARK1, 2);
            u_far.line(lefs_pkg::LS_STOP, 5);
            cmp(n == 8 ? 10'h280 : 10'h288);
        end
        $display("test lpdt done");
        // data lane ulps entry, exit and wake-up
        u_far.esc(dut.CMD_ULPS);
        wait_n(4);
        cmp(10'h180);
        u_far.line(lefs_pkg::LS_MARK1, 5);
        cmp(10'h380);
        wait_n(12);
        cmp(10'h280);
        u_far.line(lefs_pkg::LS_STOP, 6);
        cmp(10'h280);
        $display("test data ulps done");
        // clock lane ulps held until stop
        @(posedge clk);
        is_clock_lane <= 1'b1;
        u_far.line(lefs_pkg::LS_MARK1, 2);
        u_far.line(lefs_pkg::LS_BRIDGE, 5);
        cmp(10'h000);
        u_far.line(lefs_pkg::LS_MARK1, 5);
        cmp(10'h200);
        wait_n(12);
        cmp(10'h200);
        u_far.line(lefs_pkg::LS_STOP, 6);
        cmp(10'h280);
        @(posedge clk);
        is_clock_lane <= 1'b0;
        $display("test clock ulps done");
        // turn-around stays quiet; stop then bridge is illegal
        u_far.line(lefs_pkg::LS_MARK1, 2);
        u_far.line(lefs_pkg::LS_BRIDGE, 2);
        u_far.line(lefs_pkg::LS_MARK1, 5);
        cmp(10'h280);
        u_far.line(lefs_pkg::LS_STOP, 2);
        u_far.line(lefs_pkg::LS_BRIDGE, 5);
        cmp(10'h284);
        u_far.line(lefs_pkg::LS_STOP, 5);
        cmp(10'h280);
        // request then stop with no bridge, from both requests
        u_far.line(lefs_pkg::LS_MARK1, 2);
        u_far.line(lefs_pkg::LS_STOP, 5);
        cmp(10'h284);
        u_far.line(lefs_pkg::LS_MARK1, 5);
        cmp(10'h280);
        u_far.line(lefs_pkg::LS_BRIDGE, 2);
        u_far.line(lefs_pkg::LS_MARK0, 2);
        u_far.line(lefs_pkg::LS_STOP, 5);
        cmp(10'h284);
        $display("test sequence done");
        // enable low clears the held flag and masks new causes
        @(posedge clk);
        enable <= 1'b0;
        drive_en <= 1'b1;
        fight <= 1'b1;
        sot_soft_event <= 1'b1;
        wait_n(5);
        cmp(10'h280);
        u_far.line(lefs_pkg::LS_BRIDGE, 5);
        cmp(10'h280);
        @(posedge clk);
        sot_soft_event <= 1'b0;
        enable <= 1'b1;
        wait_n(6);
        $display("test enable done");
        summarize();
    end

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, flags, 10'h280);
        summarize();
    end
endmodule : lane_error_status_flags_tb_top
`default_nettype wire
